/* File: hw/monitor_result_alert_regs.sv */
`include "monitor_consts.svh"

// Summary of operation
// RULE_01: Shunt result is signed two's complement.
// RULE_02: Shunt code is 2.5 uV per count.
// RULE_03: Results show averages, not single samples.
// RULE_04: Bus code is 1.25 mV per count.
// RULE_05: Bus result top bit always reads zero.
// RULE_06: Power step equals 25 current steps.
// RULE_07: Power is current code times bus code.
// RULE_08: Current is shunt code times calibration.
// RULE_09: Calibration sets current and power resolution.
// RULE_10: Mask upper bits select alert and pin behaviour.
// RULE_11: Highest enabled comparison wins, checked per conversion.
// RULE_12: Five limit comparisons, bits 15 to 11.
// RULE_13: Current signed; calibration 15 bits unsigned.
// RULE_14: Conversion done may also drive alert pin.
// RULE_15: Done flag set late, cleared by config/read; the code keeps it on a power-down config write (mode 000 or 100).
// RULE_16: Math overflow flag marks results suspect.
module monitor_result_alert_regs
	import monitor_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT,
	parameter int CURRENT_SHIFT = `CURRENT_SHIFT_DEFAULT,
	parameter int POWER_DIV = `POWER_LSB_RATIO * `BUS_COUNTS_PER_VOLT
) (
	// System clock and reset
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	// Two-wire link
	input wire logic SCL,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	// Converter samples
	input wire logic [15:0] SHUNT_SAMPLE,
	input wire logic [15:0] BUS_SAMPLE,
	input wire logic SAMPLE_VALID,
	// Alert pin
	output logic ALERT_OUT,
	output logic ALERT_OE
);
	logic scl_m, scl_s, scl_p;
	logic sda_m, sda_s, sda_p;
	logic start_ev, stop_ev;
	logic link_run, restart_pend;
	logic [7:0] ptr_m, ptr_s;
	logic wt_m, wt_s, wt_p, rt_m, rt_s, rt_p;
	logic wr_ev, rd_ev, mask_read, cfg_write, cfg_clear;
	logic [7:0] pointer;
	word_t wr_word, rd_word, read_mux;
	logic wr_toggle, rd_toggle;
	word_t config_word, limit;
	logic [14:0] cal;
	logic [5:0] alert_en;
	logic alert_pin_polarity, alert_latch_select;
	logic limit_alert_flag, conv_done_flag, math_overflow_flag;
	word_t shunt_voltage, bus_voltage;
	word_t shunt_result, bus_result, power_result, current_result;
	logic shunt_done, bus_done;
	logic v1, v2, v3;
	logic cur_ovf, pow_ovf, pow_ovf_q, cur_ovf_q;
	logic signed [31:0] cur_full, cur_scaled;
	word_t cur_sat, cur_mag, pow_sat;
	logic [31:0] pow_full;
	logic limit_hit, alert_active;
	// Link pins seen from the system clock; start and stop need SCL high twice
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_p <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_m <= SCL;
			scl_s <= scl_m;
			scl_p <= scl_s;
			sda_m <= SDA_IN;
			sda_s <= sda_m;
			sda_p <= sda_s;
		end
	end

	assign start_ev = scl_s && scl_p && sda_p && !sda_s;
	assign stop_ev = scl_s && scl_p && !sda_p && sda_s;

	// Hold the link engine in reset between frames; a repeated start pulses it
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			link_run <= 1'b0;
			restart_pend <= 1'b0;
		end else if (start_ev) begin
			link_run <= 1'b0;
			restart_pend <= 1'b1;
		end else if (stop_ev) begin
			link_run <= 1'b0;
			restart_pend <= 1'b0;
		end else if (restart_pend) begin
			link_run <= 1'b1;
			restart_pend <= 1'b0;
		end
	end

	// Crossings back from the link domain
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ptr_m <= 8'h00;
			ptr_s <= 8'h00;
			wt_m <= 1'b0;
			wt_s <= 1'b0;
			wt_p <= 1'b0;
			rt_m <= 1'b0;
			rt_s <= 1'b0;
			rt_p <= 1'b0;
		end else begin
			ptr_m <= pointer;
			ptr_s <= ptr_m;
			wt_m <= wr_toggle;
			wt_s <= wt_m;
			wt_p <= wt_s;
			rt_m <= rd_toggle;
			rt_s <= rt_m;
			rt_p <= rt_s;
		end
	end

	assign wr_ev = wt_s ^ wt_p;
	assign rd_ev = rt_s ^ rt_p;
	assign mask_read = rd_ev && ptr_s == `REG_MASK;
	assign cfg_write = wr_ev && ptr_s == `REG_CONFIG;
	// Power-down modes are 000 and 100 in the low mode bits
	assign cfg_clear = cfg_write && wr_word[1:0] != 2'h0;

	link_engine #(
		.DEV_ADDR(DEV_ADDR)
	) u_link (
		.scl(SCL),
		.link_rst_n(link_run),
		.rst_n(RESET_N),
		.sda_in(SDA_IN),
		.sda_oe(SDA_OE),
		.rd_word(rd_word),
		.pointer(pointer),
		.wr_word(wr_word),
		.wr_toggle(wr_toggle),
		.rd_toggle(rd_toggle)
	);

	always_comb begin
		case (ptr_s)
			`REG_CONFIG: read_mux = config_word;
			`REG_SHUNT: read_mux = shunt_result;
			`REG_BUS: read_mux = {1'b0, bus_result[14:0]}; // see RULE_05
			`REG_POWER: read_mux = power_result;
			`REG_CURRENT: read_mux = current_result;
			`REG_CAL: read_mux = {1'b0, cal}; // see RULE_13
			`REG_MASK: read_mux = {alert_en, 5'h00, limit_alert_flag, conv_done_flag,
				math_overflow_flag, alert_pin_polarity, alert_latch_select};
			`REG_LIMIT: read_mux = limit;
			default: read_mux = `RST_ZERO;
		endcase
	end

	// Snapshot frozen for the whole frame so the link clock reads a stable word
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rd_word <= `RST_ZERO;
		end else if (!link_run) begin
			rd_word <= read_mux;
		end
	end

	// Writable registers
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			config_word <= `RST_CONFIG;
			cal <= 15'h0000;
			alert_en <= 6'h00;
			alert_pin_polarity <= 1'b0;
			alert_latch_select <= 1'b0;
			limit <= `RST_ZERO;
		end else if (wr_ev) begin
			case (ptr_s)
				`REG_CONFIG: config_word <= {1'b0, wr_word[14:0]};
				`REG_CAL: cal <= wr_word[14:0]; // see RULE_09
				`REG_MASK: begin
					alert_en <= wr_word[`MASK_SOL_BIT:`MASK_CONV_DONE_ALERT_ENABLE_BIT]; // see RULE_10
					alert_pin_polarity <= wr_word[`MASK_ALERT_PIN_POLARITY_BIT];
					alert_latch_select <= wr_word[`MASK_LEN_BIT];
				end
				`REG_LIMIT: limit <= wr_word;
				default: limit <= limit;
			endcase
		end
	end

	// Averaging ahead of every result register
	sample_averager u_avg_shunt (
		.clk(SYS_CLK),
		.rst_n(RESET_N),
		.restart(cfg_write),
		.avg_sel(config_word[`CFG_AVG_MSB:`CFG_AVG_LSB]),
		.sample(SHUNT_SAMPLE),
		.sample_valid(SAMPLE_VALID),
		.average(shunt_voltage),
		.done(shunt_done)
	);

	sample_averager u_avg_bus (
		.clk(SYS_CLK),
		.rst_n(RESET_N),
		.restart(cfg_write),
		.avg_sel(config_word[`CFG_AVG_MSB:`CFG_AVG_LSB]),
		.sample(BUS_SAMPLE),
		.sample_valid(SAMPLE_VALID),
		.average(bus_voltage),
		.done(bus_done)
	);

	// Current: signed shunt code times unsigned calibration, then scaled
	assign cur_full = $signed(shunt_result) * $signed({1'b0, cal}); // see RULE_08
	assign cur_scaled = cur_full >>> CURRENT_SHIFT;
	assign cur_ovf = cur_scaled > $signed(32'h00007FFF) || cur_scaled < $signed(32'hFFFF8000);
	assign cur_sat = cur_ovf ? (cur_scaled[31] ? 16'h8000 : 16'h7FFF) : cur_scaled[15:0];
	// Power from current magnitude and bus code, in steps of 25 current steps
	assign cur_mag = current_result[15] ? 16'(~current_result + 16'h0001) : current_result;
	assign pow_full = 32'(({16'h0000, cur_mag} * {16'h0000, bus_result}) /
		32'(POWER_DIV)); // see RULE_06 see RULE_07
	assign pow_ovf = |pow_full[31:16];
	assign pow_sat = pow_ovf ? 16'hFFFF : pow_full[15:0];

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			v1 <= 1'b0;
			v2 <= 1'b0;
			v3 <= 1'b0;
		end else begin
			v1 <= shunt_done && bus_done;
			v2 <= v1;
			v3 <= v2;
		end
	end

	// Result registers change only when a full average is ready
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			shunt_result <= `RST_ZERO;
			bus_result <= `RST_ZERO;
			current_result <= `RST_ZERO;
			power_result <= `RST_ZERO;
			cur_ovf_q <= 1'b0;
			pow_ovf_q <= 1'b0;
		end else begin
			if (shunt_done && bus_done) begin
				shunt_result <= shunt_voltage; // see RULE_01 see RULE_02 see RULE_03
				bus_result <= {1'b0, bus_voltage[14:0]}; // see RULE_04 see RULE_05
			end
			if (v1) begin
				current_result <= cur_sat; // see RULE_13
				cur_ovf_q <= cur_ovf;
			end
			if (v2) begin
				power_result <= pow_sat;
				pow_ovf_q <= pow_ovf;
			end
		end
	end

	// Only the highest enabled comparison counts
	always_comb begin
		if (alert_en[5]) begin
			limit_hit = $signed(shunt_result) > $signed(limit); // see RULE_11 see RULE_12
		end else if (alert_en[4]) begin
			limit_hit = $signed(shunt_result) < $signed(limit);
		end else if (alert_en[3]) begin
			limit_hit = bus_result > limit;
		end else if (alert_en[2]) begin
			limit_hit = bus_result < limit;
		end else if (alert_en[1]) begin
			limit_hit = power_result > limit;
		end else begin
			limit_hit = 1'b0;
		end
	end

	// Flags: a new event wins over a clear in the same cycle
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			conv_done_flag <= 1'b0;
			limit_alert_flag <= 1'b0;
			math_overflow_flag <= 1'b0;
		end else begin
			if (v3) begin
				conv_done_flag <= 1'b1; // see RULE_15
			end else if (mask_read || cfg_clear) begin
				conv_done_flag <= 1'b0;
			end
			if (v3 && limit_hit) begin
				limit_alert_flag <= 1'b1;
			end else if (v3 && !alert_latch_select) begin
				limit_alert_flag <= 1'b0;
			end else if (mask_read && alert_latch_select) begin
				limit_alert_flag <= 1'b0;
			end
			if (v3) begin
				math_overflow_flag <= cur_ovf_q || pow_ovf_q; // see RULE_16
			end
		end
	end

	assign alert_active = (limit_alert_flag && |alert_en[5:1]) ||
		(alert_en[0] && conv_done_flag); // see RULE_14
	// Open-drain alert: normal pulls low when active, inverted pulls low when idle
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ALERT_OE <= 1'b0;
			ALERT_OUT <= 1'b0;
			SDA_OUT <= 1'b0;
		end else begin
			ALERT_OE <= alert_active ^ alert_pin_polarity; // see RULE_10
			ALERT_OUT <= 1'b0;
			SDA_OUT <= 1'b0;
		end
	end
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RESET_N);
	property p_bus_msb;
		bus_result[15] == 1'b0 && (ptr_s != `REG_BUS || read_mux[15] == 1'b0);
	endproperty
	a_bus_msb: assert property (p_bus_msb) else $error("bus msb set"); // see RULE_05
	property p_hold_results;
		!(shunt_done && bus_done) |=> $stable(shunt_result) && $stable(bus_result);
	endproperty
	a_hold_results: assert property (p_hold_results) else $error("result moved"); // see RULE_03
	property p_zero_cal;
		v1 && cal == 15'h0000 |=> current_result == 16'h0000;
	endproperty
	a_zero_cal: assert property (p_zero_cal) else $error("current not zero"); // see RULE_08
	property p_zero_bus;
		v2 && bus_result == 16'h0000 |=> power_result == 16'h0000;
	endproperty
	a_zero_bus: assert property (p_zero_bus) else $error("power not zero"); // see RULE_07
	// Shunt and bus results land one cycle after done, flags three pipeline stages later
	property p_done_sets;
		(shunt_done && bus_done) |-> ##4 conv_done_flag;
	endproperty
	a_done_sets: assert property (p_done_sets) else $error("done flag late"); // see RULE_15
	property p_done_clears;
		(mask_read || cfg_clear) && !v3 |=> !conv_done_flag;
	endproperty
	a_done_clears: assert property (p_done_clears) else $error("done flag kept"); // see RULE_15
	property p_shunt_over;
		v3 && alert_en[5] && $signed(shunt_result) > $signed(limit) |=> limit_alert_flag;
	endproperty
	a_shunt_over: assert property (p_shunt_over) else $error("alert missed"); // see RULE_11
	property p_pin_level;
		alert_en[0] && conv_done_flag |=> ALERT_OE == !$past(alert_pin_polarity);
	endproperty
	a_pin_level: assert property (p_pin_level) else $error("alert pin wrong"); // see RULE_14
	property p_ovf;
		v3 && cur_ovf_q |=> math_overflow_flag;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow missed"); // see RULE_16
	c_read: cover property (mask_read ##1 !conv_done_flag);
	c_done: cover property (v3 ##1 conv_done_flag ##[1:100] !conv_done_flag);
	c_alert: cover property (v3 && limit_hit ##1 ALERT_OE);
endmodule

/* File: hw/monitor_consts.svh */
`ifndef MONITOR_CONSTS_SVH
`define MONITOR_CONSTS_SVH

// Register pointers on the two-wire port
`define REG_CONFIG 8'h00
`define REG_SHUNT 8'h01
`define REG_BUS 8'h02
`define REG_POWER 8'h03
`define REG_CURRENT 8'h04
`define REG_CAL 8'h05
`define REG_MASK 8'h06
`define REG_LIMIT 8'h07

// Alert mask/enable field positions
`define MASK_SOL_BIT 15
`define MASK_CONV_DONE_ALERT_ENABLE_BIT 10
`define MASK_AFF_BIT 4
`define MASK_CONV_DONE_FLAG_BIT 3
`define MASK_OVF_BIT 2
`define MASK_ALERT_PIN_POLARITY_BIT 1
`define MASK_LEN_BIT 0

// Configuration fields used here
`define CFG_AVG_MSB 11
`define CFG_AVG_LSB 9

// Reset values
`define RST_ZERO 16'h0000
`define RST_CONFIG 16'h4127

// Scaling: power step is this many current steps
`define POWER_LSB_RATIO 25
// Bus step in microvolts, so one volt is 800 counts
`define BUS_LSB_UV 1250
`define BUS_COUNTS_PER_VOLT (1000000 / `BUS_LSB_UV)
`define CURRENT_SHIFT_DEFAULT 11
// Arbitrary neutral default for the device address
`define DEV_ADDR_DEFAULT 7'h40

`endif

/* File: hw/monitor_pkg.sv */
package monitor_pkg;
	typedef logic [15:0] word_t;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_PTR,
		ST_WMSB,
		ST_WLSB,
		ST_RMSB,
		ST_RLSB
	} xfer_stage_e;
endpackage

/* File: hw/sample_averager.sv */
module sample_averager
	import monitor_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int ACC_WIDTH = 26
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic restart,
	input wire logic [2:0] avg_sel,
	// Samples in
	input wire logic signed [WIDTH-1:0] sample,
	input wire logic sample_valid,
	// Average out
	output logic signed [WIDTH-1:0] average,
	output logic done
);
	function automatic logic [3:0] avg_shift(input logic [2:0] sel);
		case (sel)
			3'h0: avg_shift = 4'h0;
			3'h1: avg_shift = 4'h2;
			3'h2: avg_shift = 4'h4;
			3'h3: avg_shift = 4'h6;
			3'h4: avg_shift = 4'h7;
			3'h5: avg_shift = 4'h8;
			3'h6: avg_shift = 4'h9;
			default: avg_shift = 4'hA;
		endcase
	endfunction

	logic signed [ACC_WIDTH-1:0] acc;
	logic signed [ACC_WIDTH-1:0] next_acc;
	logic [10:0] count;
	logic [10:0] target;

	assign next_acc = acc + ACC_WIDTH'(sample);
	assign target = 11'h001 << avg_shift(avg_sel);

	// Only a completed set of samples reaches the output
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc <= '0;
			count <= 11'h000;
			average <= '0;
			done <= 1'b0;
		end else if (restart) begin
			acc <= '0;
			count <= 11'h000;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (sample_valid) begin
				if (11'(count + 11'h001) == target) begin
					average <= WIDTH'(next_acc >>> avg_shift(avg_sel));
					acc <= '0;
					count <= 11'h000;
					done <= 1'b1;
				end else begin
					acc <= next_acc;
					count <= 11'(count + 11'h001);
				end
			end
		end
	end
endmodule

/* File: hw/link_engine.sv */
`include "monitor_consts.svh"

module link_engine
	import monitor_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
	// Link clock and resets
	input wire logic scl,
	input wire logic link_rst_n,
	input wire logic rst_n,
	// Data pin
	input wire logic sda_in,
	output logic sda_oe,
	// Towards the system domain
	input wire logic [15:0] rd_word,
	output logic [7:0] pointer,
	output logic [15:0] wr_word,
	output logic wr_toggle,
	output logic rd_toggle
);
	xfer_stage_e stage;
	xfer_stage_e next_stage;
	logic [3:0] bitcnt;
	logic [7:0] shift;
	logic [7:0] wr_msb;
	logic rx_ack;
	logic tx_stage;

	assign rx_ack = (stage == ST_ADDR && shift[7:1] == DEV_ADDR) || stage == ST_PTR ||
		stage == ST_WMSB || stage == ST_WLSB;
	assign tx_stage = stage == ST_RMSB || stage == ST_RLSB;

	always_comb begin
		case (stage)
			ST_ADDR: next_stage = rx_ack ? (shift[0] ? ST_RMSB : ST_PTR) : ST_IDLE;
			ST_PTR: next_stage = ST_WMSB;
			ST_WMSB: next_stage = ST_WLSB;
			ST_RMSB: next_stage = sda_in ? ST_IDLE : ST_RLSB;
			default: next_stage = ST_IDLE;
		endcase
	end

	// Byte framing; the reset is held between frames, so leaving it means a start
	always_ff @(posedge scl or negedge link_rst_n) begin
		if (!link_rst_n) begin
			stage <= ST_ADDR;
			bitcnt <= 4'h0;
			shift <= 8'h00;
		end else if (stage != ST_IDLE) begin
			if (bitcnt != 4'h8) begin
				shift <= {shift[6:0], sda_in};
				bitcnt <= 4'(bitcnt + 4'h1);
			end else begin
				bitcnt <= 4'h0;
				stage <= next_stage;
			end
		end
	end

	// Pointer and write data survive between frames
	always_ff @(posedge scl or negedge rst_n) begin
		if (!rst_n) begin
			pointer <= 8'h00;
			wr_msb <= 8'h00;
			wr_word <= `RST_ZERO;
			wr_toggle <= 1'b0;
			rd_toggle <= 1'b0;
		end else if (bitcnt == 4'h8) begin
			case (stage)
				ST_PTR: pointer <= shift;
				ST_WMSB: wr_msb <= shift;
				ST_WLSB: begin
					wr_word <= {wr_msb, shift};
					wr_toggle <= ~wr_toggle;
				end
				ST_ADDR: begin
					if (rx_ack && shift[0]) begin
						rd_toggle <= ~rd_toggle;
					end
				end
				default: wr_msb <= wr_msb;
			endcase
		end
	end

	// Data changes only while the clock is low
	always_ff @(negedge scl or negedge link_rst_n) begin
		if (!link_rst_n) begin
			sda_oe <= 1'b0;
		end else if (bitcnt == 4'h8) begin
			sda_oe <= rx_ack && !tx_stage;
		end else if (tx_stage) begin
			sda_oe <= ~rd_word[{stage == ST_RMSB, ~bitcnt[2:0]}];
		end else begin
			sda_oe <= 1'b0;
		end
	end
endmodule

/* File: verif/bus_host_model.sv */
module bus_host_model (
	// Two-wire side
	output logic scl,
	output logic sda_line,
	input wire logic sda_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	logic sda_low;

	// Pull-up wins unless some party pulls the wire low
	assign sda_line = ~(sda_low | sda_oe);

	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// One bit: data changes only while the clock is low, sampled at the rise
	task automatic bit_out(input logic b, output logic seen);
		sda_low = ~b;
		#40 scl = 1'b1;
		seen = sda_line;
		#80 scl = 1'b0;
		#40;
	endtask

	task automatic byte_io(input logic [7:0] tx, input logic ack_bit, output logic [7:0] rx,
		output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_out(tx[i], rx[i]);
		end
		bit_out(ack_bit, ack);
	endtask

	// Long hold after the start edge lets the device's detector catch it
	task automatic start();
		sda_low = 1'b0;
		scl = 1'b1;
		#100 sda_low = 1'b1;
		#300 scl = 1'b0;
		#40;
	endtask

	// Clock then stays high, so the link clock stands still between frames
	task automatic stop();
		sda_low = 1'b1;
		#40 scl = 1'b1;
		#120 sda_low = 1'b0;
		#1200;
	endtask

	task automatic write_reg(input logic [6:0] addr, input logic [7:0] ptr,
		input logic [15:0] data, output logic nack);
		logic [7:0] rx;
		logic a0;
		logic a1;
		logic a2;
		logic a3;
		start();
		byte_io({addr, 1'b0}, 1'b1, rx, a0);
		byte_io(ptr, 1'b1, rx, a1);
		byte_io(data[15:8], 1'b1, rx, a2);
		byte_io(data[7:0], 1'b1, rx, a3);
		stop();
		nack = a0 | a1 | a2 | a3;
	endtask

	task automatic read_reg(input logic [6:0] addr, input logic [7:0] ptr,
		output logic [15:0] data, output logic nack);
		logic [7:0] rx;
		logic a0;
		logic a1;
		logic a2;
		logic ign;
		start();
		byte_io({addr, 1'b0}, 1'b1, rx, a0);
		byte_io(ptr, 1'b1, rx, a1);
		stop();
		start();
		byte_io({addr, 1'b1}, 1'b1, rx, a2);
		byte_io(8'hFF, 1'b0, data[15:8], ign);
		byte_io(8'hFF, 1'b1, data[7:0], ign);
		stop();
		nack = a0 | a1 | a2;
	endtask
endmodule

/* File: verif/monitor_result_alert_regs_test.sv */
`include "monitor_consts.svh"

module monitor_result_alert_regs_test import monitor_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int CUR_SHIFT = 11;
	localparam int POW_DIV = 20000;
	localparam logic [6:0] DEV = 7'h40;

	logic sys_clk, reset_n, scl, sda_in, sda_out, sda_oe, sample_valid, alert_out, alert_oe;
	logic [15:0] shunt_sample, bus_sample;
	int n_fail = 0;
	int samples_checked = 0;

	monitor_result_alert_regs #(.DEV_ADDR(DEV), .CURRENT_SHIFT(CUR_SHIFT), .POWER_DIV(POW_DIV))
	u_monitor_result_alert_regs (.SYS_CLK(sys_clk), .RESET_N(reset_n), .SCL(scl),
		.SDA_IN(sda_in), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SHUNT_SAMPLE(shunt_sample),
		.BUS_SAMPLE(bus_sample), .SAMPLE_VALID(sample_valid), .ALERT_OUT(alert_out),
		.ALERT_OE(alert_oe));

	bus_host_model u_bus_host_model (.scl(scl), .sda_line(sda_in), .sda_oe(sda_oe));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic check(input string name, input word_t exp, input word_t seen);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] ptr, input word_t data);
		logic nk;
		u_bus_host_model.write_reg(DEV, ptr, data, nk);
		check("write ack", 16'h0000, {15'h0000, nk});
	endtask

	task automatic rd_chk(input string name, input logic [7:0] ptr, input word_t exp);
		word_t v;
		logic nk;
		u_bus_host_model.read_reg(DEV, ptr, v, nk);
		check(name, exp, v);
	endtask

	// One sample pair, then enough cycles for results, flags and pin to settle
	task automatic conv(input word_t sh, input word_t bu);
		@(negedge sys_clk);
		shunt_sample = sh;
		bus_sample = bu;
		sample_valid = 1'b1;
		@(negedge sys_clk);
		sample_valid = 1'b0;
		repeat (12) @(negedge sys_clk);
	endtask

	function automatic word_t cur_of(input word_t sh, input word_t cal);
		longint p;
		p = longint'($signed(sh)) * longint'(cal);
		p = p >>> CUR_SHIFT;
		if (p > 32767) p = 32767;
		else if (p < -32768) p = -32768;
		return p[15:0];
	endfunction

	function automatic word_t pow_of(input word_t cur, input word_t bu);
		longint c;
		c = longint'($signed(cur));
		if (c < 0) c = -c;
		c = c * longint'(bu) / POW_DIV;
		return (c > 65535) ? 16'hFFFF : c[15:0];
	endfunction

	task automatic t_reset();
		for (int p = 1; p <= 6; p++) begin
			rd_chk("reset value", 8'(p), 16'h0000);
		end
		rd_chk("unmapped", 8'h08, 16'h0000);
		wr(`REG_SHUNT, 16'h1234);
		rd_chk("read-only shunt", `REG_SHUNT, 16'h0000);
		$display("test reset done");
	endtask

	task automatic t_cal();
		logic nk;
		wr(`REG_CAL, 16'h9234);
		rd_chk("cal top bit", `REG_CAL, 16'h1234);
		u_bus_host_model.write_reg(7'h41, `REG_CAL, 16'h5555, nk);
		check("foreign address", 16'h0001, {15'h0000, nk});
		rd_chk("cal kept", `REG_CAL, 16'h1234);
		$display("test calibration done");
	endtask

	task automatic t_math();
		wr(`REG_CAL, 16'h0C00);
		conv(16'hF830, 16'h7FFF);
		rd_chk("shunt", `REG_SHUNT, 16'hF830);
		rd_chk("bus full scale", `REG_BUS, 16'h7FFF);
		rd_chk("current", `REG_CURRENT, cur_of(16'hF830, 16'h0C00));
		rd_chk("power", `REG_POWER, pow_of(cur_of(16'hF830, 16'h0C00), 16'h7FFF));
		rd_chk("done flag", `REG_MASK, 16'h0008);
		rd_chk("done cleared by read", `REG_MASK, 16'h0000);
		$display("test math done");
	endtask

	task automatic t_avg();
		wr(`REG_CONFIG, 16'h4327);
		conv(16'h0064, 16'h03E8);
		conv(16'h00C8, 16'h03E8);
		conv(16'h012C, 16'h07D0);
		rd_chk("done before last sample", `REG_MASK, 16'h0000);
		conv(16'h0190, 16'h07D0);
		rd_chk("avg shunt", `REG_SHUNT, 16'h00FA);
		rd_chk("avg bus", `REG_BUS, 16'h05DC);
		rd_chk("avg current", `REG_CURRENT, cur_of(16'h00FA, 16'h0C00));
		rd_chk("avg power", `REG_POWER, pow_of(cur_of(16'h00FA, 16'h0C00), 16'h05DC));
		wr(`REG_CONFIG, 16'h4127);
		rd_chk("done cleared by config", `REG_MASK, 16'h0000);
		$display("test averaging done");
	endtask

	// Five limit functions, a priority clash and inverted polarity
	task automatic t_alert();
		word_t msk [7] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h9000, 16'h8002};
		word_t sh [7] = '{16'h2000, 16'h0100, 16'h0100, 16'h2000, 16'h4000, 16'h0100, 16'h0100};
		word_t bu [7] = '{16'h0100, 16'h0100, 16'h2000, 16'h0100, 16'h4000, 16'h0100, 16'h2000};
		logic oe [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
		logic aff [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
		wr(`REG_CAL, 16'h0800);
		wr(`REG_LIMIT, 16'h1000);
		for (int i = 0; i < 7; i++) begin
			wr(`REG_MASK, msk[i]);
			conv(sh[i], bu[i]);
			check("alert pin", {15'h0000, oe[i]}, {15'h0000, alert_oe});
			rd_chk("alert flags", `REG_MASK, msk[i] | {11'h000, aff[i], 4'h8});
		end
		$display("test alert done");
	endtask

	task automatic t_conv_done_alert_enable();
		wr(`REG_MASK, 16'h0400);
		conv(16'h0100, 16'h0100);
		check("ready on pin", 16'h0001, {15'h0000, alert_oe});
		rd_chk("ready flag", `REG_MASK, 16'h0408);
		repeat (4) @(negedge sys_clk);
		check("pin after read", 16'h0000, {15'h0000, alert_oe});
		$display("test conversion ready done");
	endtask

	task automatic t_overflow();
		wr(`REG_MASK, 16'h0000);
		wr(`REG_CAL, 16'h0C00);
		conv(16'h8300, 16'h0320);
		rd_chk("negative shunt", `REG_SHUNT, 16'h8300);
		rd_chk("saturated current", `REG_CURRENT, cur_of(16'h8300, 16'h0C00));
		rd_chk("overflow flag", `REG_MASK, 16'h000C);
		$display("test overflow done");
	endtask

	// Latch mode holds the flag until a read; a power-down config write keeps done
	task automatic t_latch();
		rd_chk("limit kept", `REG_LIMIT, 16'h1000);
		wr(`REG_MASK, 16'h8001);
		conv(16'h2000, 16'h0100);
		conv(16'h0100, 16'h0100);
		check("latched pin", 16'h0001, {15'h0000, alert_oe});
		check("open-drain data", 16'h0000, {14'h0000, sda_out, alert_out});
		wr(`REG_CONFIG, 16'h4124);
		rd_chk("latched flag", `REG_MASK, 16'h8019);
		repeat (4) @(negedge sys_clk);
		check("pin after latch read", 16'h0000, {15'h0000, alert_oe});
		rd_chk("latch cleared", `REG_MASK, 16'h8001);
		$display("test latch done");
	endtask

	initial begin
		reset_n = 1'b0;
		sample_valid = 1'b0;
		shunt_sample = 16'h0000;
		bus_sample = 16'h0000;
		repeat (2) @(negedge sys_clk);
		reset_n = 1'b1;
		repeat (6) @(negedge sys_clk);
		#7;
		t_reset();
		t_cal();
		t_math();
		t_avg();
		t_alert();
		t_conv_done_alert_enable();
		t_overflow();
		t_latch();
		final_report();
	end

	// Tests need about half a millisecond
	initial begin
		#2000000;
		n_fail++;
		final_report();
	end
endmodule
